// [common/dt_pkg.sv]
package dt_pkg;
   localparam int DATA_W = 64;
   localparam int PAR_W = 8;
   localparam int BURST_BEATS = 4;
   localparam int RAM_DEPTH = 16;
   localparam int RAM_AW = 4;
   localparam int IRQ_SRC = 4;
   localparam logic [63:0] DATA_RST = 64'h0;
   localparam logic [7:0] PAR_RST = 8'h0;
   localparam logic [2:0] BEAT_RST = 3'h0;
   localparam logic [2:0] BEAT_LAST_BURST = 3'h3;

   function automatic logic [7:0] odd_par(input logic [63:0] d);
      logic [7:0] p;
      p = 8'h0;
      for (int i = 0; i < 8; i++) begin
         p[i] = ~(^d[i*8 +: 8]);
      end
      return p;
   endfunction
endpackage

// [common/dt_bus_if.sv]
interface dt_bus_if;
   import dt_pkg::*;
   logic [63:0] d_dev_o;
   logic [63:0] d_bus_o;
   logic d_dev_oe;
   logic d_bus_oe;
   logic [7:0] dp_dev_o;
   logic [7:0] dp_bus_o;
   logic ta_n_dev_o;
   logic ta_n_dev_oe;
   logic ta_n_bus_o;
   logic ta_n_bus_oe;
   logic dbb_n_o;
   logic dbb_n_oe;
   logic gbl_n;
   logic irq_n;
   logic slave_claim_out;
   logic master_data_grant_in;
   logic slave_data_grant_in;
   logic burst_n;
   logic dev_write;
   logic [63:0] d_line;
   logic [7:0] dp_line;
   logic ta_n_line;
   logic dev_room;
   logic bus_room;
   // wired bus resolution, pull-ups when nobody drives
   assign d_line = d_dev_oe ? d_dev_o : (d_bus_oe ? d_bus_o : 64'hffffffffffffffff);
   assign dp_line = d_dev_oe ? dp_dev_o : (d_bus_oe ? dp_bus_o : 8'hff);
   assign ta_n_line = (ta_n_dev_oe & ta_n_dev_o) | (ta_n_bus_oe & ta_n_bus_o)
                      | (~ta_n_dev_oe & ~ta_n_bus_oe) ? 1'b1 : 1'b0;
   modport dev (
      output d_dev_o, d_dev_oe, dp_dev_o, ta_n_dev_o, ta_n_dev_oe, dbb_n_o, dbb_n_oe,
      output gbl_n, irq_n, slave_claim_out, dev_room,
      input d_bus_oe, bus_room,
      input master_data_grant_in, slave_data_grant_in, burst_n, dev_write,
      input d_line, dp_line, ta_n_line
   );
   modport sys (
      output d_bus_o, d_bus_oe, dp_bus_o, ta_n_bus_o, ta_n_bus_oe, bus_room,
      input d_dev_oe, dev_room,
      output master_data_grant_in, slave_data_grant_in, burst_n, dev_write,
      input dbb_n_o, dbb_n_oe, gbl_n, irq_n, slave_claim_out,
      input d_line, dp_line, ta_n_line
   );
endinterface

// [hw/dt_device.sv]
module dt_device (
   input wire logic sys_clk,
   input wire logic rst_n,
   dt_bus_if.dev bus,
   input wire logic mst_req,
   input wire logic mst_write,
   input wire logic mst_burst,
   input wire logic mst_global,
   input wire logic slv_claim,
   input wire logic slv_read,
   input wire logic slv_burst,
   input wire logic [dt_pkg::IRQ_SRC-1:0] unit_irq,
   input wire logic [dt_pkg::DATA_W-1:0] tx_data,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic [dt_pkg::DATA_W-1:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready,
   output logic busy,
   output logic ram_clear_done
);
   import dt_pkg::*;
   typedef enum logic [2:0] {ST_IDLE, ST_MWAIT, ST_MDATA, ST_SWAIT, ST_SDATA, ST_REL} st_e;
   st_e st_ff, nxt_st;
   logic [2:0] beat_ff;
   logic [2:0] last_beat_ff;
   logic wr_ff;
   logic slave_ff;
   logic [63:0] d_ff;
   logic [7:0] dp_ff;
   logic d_oe_ff;
   logic ta_n_c;
   logic ta_oe_c;
   logic room;
   logic data_st;
   logic can_load;
   logic [2:0] ld_ff;
   logic dbb_n_ff;
   logic dbb_oe_ff;
   logic gbl_n_ff;
   logic claim_ff;
   logic irq_n_ff;
   logic [1:0] master_data_grant_in_sync_ff, slave_data_grant_in_sync_ff;
   logic [63:0] rx_d_ff;
   logic [63:0] ram_ff [RAM_DEPTH];
   logic [RAM_AW-1:0] clr_addr_ff;
   logic clr_done_ff;
   logic ack_in;
   logic final_beat;

   // grants pass two flops, active low
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         master_data_grant_in_sync_ff <= 2'h3;
         slave_data_grant_in_sync_ff <= 2'h3;
      end else begin
         master_data_grant_in_sync_ff <= {master_data_grant_in_sync_ff[0], bus.master_data_grant_in};
         slave_data_grant_in_sync_ff <= {slave_data_grant_in_sync_ff[0], bus.slave_data_grant_in};
      end
   end

   // ack is same-clock logic: read directly, a synchroniser would split it from its beat
   assign data_st = (st_ff == ST_MDATA) || (st_ff == ST_SDATA);
   assign ack_in = data_st && !bus.ta_n_line;
   // a beat stays on the lines until acknowledged, so ack and data coincide
   assign can_load = data_st && wr_ff && (ld_ff <= last_beat_ff) && !(d_oe_ff && !ack_in);
   assign final_beat = ack_in && (beat_ff == last_beat_ff);
   assign tx_ready = can_load;
   assign room = !rx_valid || rx_ready;

   always_comb begin
      nxt_st = st_ff;
      case (st_ff)
         ST_IDLE: begin
            if (!clr_done_ff) nxt_st = ST_IDLE;
            else if (slv_claim) nxt_st = ST_SWAIT;
            else if (mst_req) nxt_st = ST_MWAIT;
         end
         ST_MWAIT: if (!master_data_grant_in_sync_ff[1]) nxt_st = ST_MDATA;
         ST_SWAIT: if (!wr_ff || !slave_data_grant_in_sync_ff[1]) nxt_st = ST_SDATA;
         ST_MDATA, ST_SDATA: if (final_beat) nxt_st = ST_REL;
         ST_REL: nxt_st = ST_IDLE;
         default: nxt_st = ST_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) st_ff <= ST_IDLE;
      else st_ff <= nxt_st;
   end

   // transfer attributes captured at start
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ff <= 1'b0;
         slave_ff <= 1'b0;
         last_beat_ff <= BEAT_RST;
      end else if (st_ff == ST_IDLE && clr_done_ff && (slv_claim || mst_req)) begin
         slave_ff <= slv_claim;
         // high when this end drives the data lines
         wr_ff <= slv_claim ? slv_read : mst_write;
         last_beat_ff <= (slv_claim ? slv_burst : mst_burst) ? BEAT_LAST_BURST : BEAT_RST;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) beat_ff <= BEAT_RST;
      else if (st_ff == ST_IDLE) beat_ff <= BEAT_RST;
      else if (ack_in) beat_ff <= beat_ff + 3'h1;
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) ld_ff <= BEAT_RST;
      else if (st_ff == ST_IDLE) ld_ff <= BEAT_RST;
      else if (can_load && tx_valid) ld_ff <= ld_ff + 3'h1;
   end

   // data, parity and enable; drives only for own write-master or read-slave beats
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         d_ff <= DATA_RST;
         dp_ff <= PAR_RST;
         d_oe_ff <= 1'b0;
      end else begin
         if (can_load && tx_valid) begin
            d_ff <= tx_data;
            dp_ff <= odd_par(tx_data);
            d_oe_ff <= 1'b1;
         end else if (ack_in || !data_st) begin
            d_oe_ff <= 1'b0;
         end
      end
   end

   // claiming slave acks when a beat stands and its receiver has room
   assign ta_oe_c = slave_ff && (st_ff == ST_SDATA);
   assign ta_n_c = ~(ta_oe_c && (wr_ff ? (d_oe_ff && bus.bus_room) : (bus.d_bus_oe && room)));

   // busy: low through tenure, one cycle high after last ack, then released
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dbb_n_ff <= 1'b1;
         dbb_oe_ff <= 1'b0;
      end else begin
         dbb_n_ff <= ~(nxt_st == ST_MDATA || nxt_st == ST_SDATA);
         dbb_oe_ff <= (nxt_st == ST_MDATA || nxt_st == ST_SDATA || nxt_st == ST_REL);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         gbl_n_ff <= 1'b1;
         claim_ff <= 1'b0;
         irq_n_ff <= 1'b1;
      end else begin
         gbl_n_ff <= ~(mst_global && !slave_ff && (st_ff == ST_MWAIT || st_ff == ST_MDATA));
         claim_ff <= slave_ff && (st_ff == ST_SWAIT || st_ff == ST_SDATA);
         irq_n_ff <= ~(|unit_irq);
      end
   end

   // inbound beats land in receive register; rx_ready stall holds off the ack until the register has room
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_d_ff <= DATA_RST;
         rx_valid <= 1'b0;
      end else begin
         if (rx_ready) rx_valid <= 1'b0;
         if (ack_in && !wr_ff) begin
            rx_d_ff <= bus.d_line;
            rx_valid <= 1'b1;
         end
      end
   end

   // scratch ram wiped one word per cycle after reset release
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         clr_addr_ff <= '0;
         clr_done_ff <= 1'b0;
      end else if (!clr_done_ff) begin
         clr_addr_ff <= clr_addr_ff + 1'b1;
         if (clr_addr_ff == RAM_AW'(RAM_DEPTH - 1)) clr_done_ff <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!clr_done_ff) ram_ff[clr_addr_ff] <= DATA_RST;
      else if (rx_valid && rx_ready) ram_ff[beat_ff[1:0]] <= rx_d_ff;
   end

   assign rx_data = rx_d_ff;
   assign busy = (st_ff != ST_IDLE);
   assign ram_clear_done = clr_done_ff;
   assign bus.d_dev_o = d_ff;
   assign bus.dp_dev_o = dp_ff;
   assign bus.d_dev_oe = d_oe_ff;
   assign bus.ta_n_dev_o = ta_n_c;
   assign bus.ta_n_dev_oe = ta_oe_c;
   assign bus.dev_room = room;
   assign bus.dbb_n_o = dbb_n_ff;
   assign bus.dbb_n_oe = dbb_oe_ff;
   assign bus.gbl_n = gbl_n_ff;
   assign bus.irq_n = irq_n_ff;
   assign bus.slave_claim_out = claim_ff;
endmodule // dt_device

// [hw/dt_system.sv]
module dt_system #(
   parameter int DEPTH = 2
) (
   input wire logic sys_clk,
   input wire logic rst_n,
   dt_bus_if.sys bus,
   input wire logic grant_master,
   input wire logic grant_slave,
   input wire logic burst,
   input wire logic dev_writes,
   input wire logic [dt_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_valid,
   output logic wr_ready,
   output logic [dt_pkg::DATA_W-1:0] rd_data,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic parity_err,
   output logic dev_busy,
   output logic dev_irq
);
   import dt_pkg::*;
   logic [1:0] dbb_sync_ff, irq_sync_ff;
   logic [63:0] buf_ff [DEPTH];
   logic [0:0] wp_ff, rp_ff;
   logic [1:0] cnt_ff;
   logic [63:0] d_ff;
   logic [7:0] dp_ff;
   logic oe_ff, perr_ff;
   logic tenure, own_ta, ack, room, drv, push, pop;

   // synchronised copies feed status outputs only, never the handshake
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         dbb_sync_ff <= 2'h3;
         irq_sync_ff <= 2'h3;
      end else begin
         dbb_sync_ff <= {dbb_sync_ff[0], bus.dbb_n_oe ? bus.dbb_n_o : 1'b1};
         irq_sync_ff <= {irq_sync_ff[0], bus.irq_n};
      end
   end

   assign tenure = bus.dbb_n_oe && !bus.dbb_n_o;
   // a claiming device acks its own tenures; this end acks the rest
   assign own_ta = tenure && !bus.slave_claim_out;
   assign ack = tenure && !bus.ta_n_line;
   assign room = (cnt_ff != 2'h2);
   // two-entry buffer of data received from the device; ack waits for room
   assign push = ack && dev_writes;
   assign pop = rd_valid && rd_ready;
   assign drv = tenure && !dev_writes;
   assign rd_valid = (cnt_ff != 2'h0);
   assign rd_data = buf_ff[rp_ff];

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wp_ff <= 1'b0;
         rp_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else begin
         if (push && room) wp_ff <= wp_ff + 1'b1;
         if (pop) rp_ff <= rp_ff + 1'b1;
         cnt_ff <= cnt_ff + 2'((push && room) ? 1 : 0) - 2'(pop ? 1 : 0);
      end
   end

   always_ff @(posedge sys_clk) begin
      if (push && room) buf_ff[wp_ff] <= bus.d_line;
   end

   // memory side drives data when device reads as master or writes to claimed slave
   // a loaded beat is held until acknowledged
   assign wr_ready = drv && !(oe_ff && !ack);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         d_ff <= DATA_RST;
         dp_ff <= PAR_RST;
         oe_ff <= 1'b0;
         perr_ff <= 1'b0;
      end else begin
         if (wr_ready && wr_valid) begin
            d_ff <= wr_data;
            dp_ff <= odd_par(wr_data);
            oe_ff <= 1'b1;
         end else if (ack || !drv) begin
            oe_ff <= 1'b0;
         end
         perr_ff <= push && (bus.dp_line != odd_par(bus.d_line));
      end
   end

   assign bus.d_bus_o = d_ff;
   assign bus.dp_bus_o = dp_ff;
   assign bus.d_bus_oe = oe_ff;
   // ack only when a beat stands and its receiver has room
   assign bus.ta_n_bus_o = ~(own_ta && (dev_writes ? (bus.d_dev_oe && room) : (oe_ff && bus.dev_room)));
   assign bus.ta_n_bus_oe = own_ta;
   assign bus.bus_room = room;
   assign bus.master_data_grant_in = ~grant_master;
   assign bus.slave_data_grant_in = ~grant_slave;
   assign bus.burst_n = ~burst;
   assign bus.dev_write = dev_writes;
   assign parity_err = perr_ff;
   assign dev_busy = ~dbb_sync_ff[1];
   assign dev_irq = ~irq_sync_ff[1];
endmodule // dt_system

// [bench/dt_bus_sva.sv]
module dt_bus_sva (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [63:0] d_line,
   input wire logic [7:0] dp_line,
   input wire logic d_dev_oe,
   input wire logic d_bus_oe,
   input wire logic ta_n_line,
   input wire logic ta_n_dev_o,
   input wire logic ta_n_dev_oe,
   input wire logic dbb_n_o,
   input wire logic dbb_n_oe,
   input wire logic slave_claim_out,
   input wire logic master_data_grant_in,
   input wire logic slave_data_grant_in
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [7:0] lane_odd;
   logic [2:0] beats_ff;
   logic dbb_act;
   assign dbb_act = dbb_n_oe & ~dbb_n_o;
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         lane_odd[i] = ^{d_line[i*8 +: 8], dp_line[i]};
      end
   end
   // beat count of the running tenure, still visible in the release cycle
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         beats_ff <= 3'h0;
      end else if (dbb_act) begin
         beats_ff <= beats_ff + {2'h0, ~ta_n_line};
      end else begin
         beats_ff <= 3'h0;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence s_busy_end;
      dbb_act ##1 (dbb_n_oe && dbb_n_o);
   endsequence
   sequence s_master_start;
      !dbb_act ##1 (dbb_act && !slave_claim_out);
   endsequence
   property p_parity; !ta_n_line |-> lane_odd == 8'hff; endproperty
   a_parity: assert property (p_parity) else $error("even parity on a beat");
   property p_beat_data; !ta_n_line |-> (d_dev_oe || d_bus_oe); endproperty
   a_beat_data: assert property (p_beat_data) else $error("ack without data");
   property p_hold; d_dev_oe |-> dbb_act; endproperty
   a_hold: assert property (p_hold) else $error("data driven while busy negated");
   property p_release; s_busy_end |=> !dbb_n_oe; endproperty
   a_release: assert property (p_release) else $error("busy line not released");
   property p_beats; s_busy_end |-> (beats_ff == 3'h1 || beats_ff == 3'h4); endproperty
   a_beats: assert property (p_beats) else $error("wrong beat count");
   property p_grant; s_master_start |-> $past(master_data_grant_in, 2) == 1'b0; endproperty
   a_grant: assert property (p_grant) else $error("master tenure without grant");
   property p_own; d_dev_oe |-> (slave_claim_out ? !slave_data_grant_in : !master_data_grant_in); endproperty
   a_own: assert property (p_own) else $error("data driven outside own tenure");
   property p_claim_ta; (ta_n_dev_oe && !ta_n_dev_o) |-> slave_claim_out; endproperty
   a_claim_ta: assert property (p_claim_ta) else $error("ack without claim");
endmodule // dt_bus_sva

// [bench/host_bus_data_tenure_test.sv]
`define CHECK(a, b, m) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
   $display("unexpected at %0t: %s", $time, m); end end
`define WAITC(c) begin int w; w = 0; do begin @(posedge sys_clk); w++; end \
   while ((c) !== 1'b1 && w < 400); if ((c) !== 1'b1) begin n_errors++; end_of_test(); end end
module host_bus_data_tenure_test import dt_pkg::*;;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk, rst_n, mst_req, mst_write, mst_burst, mst_global, slv_claim, slv_read, slv_burst;
   logic [IRQ_SRC-1:0] unit_irq;
   logic [63:0] tx_data, wr_data, rx_data, rd_data;
   logic tx_valid, tx_ready, rx_valid, rx_ready, busy, ram_clear_done, grant_master, grant_slave;
   logic burst, dev_writes, wr_valid, wr_ready, rd_valid, rd_ready, parity_err, dev_busy, dev_irq;
   int n_errors, tests_run, seq, gbl_cnt;
   dt_bus_if bus ();
   dt_device dt_device_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus), .mst_req(mst_req),
      .mst_write(mst_write), .mst_burst(mst_burst), .mst_global(mst_global), .slv_claim(slv_claim),
      .slv_read(slv_read), .slv_burst(slv_burst), .unit_irq(unit_irq), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .busy(busy), .ram_clear_done(ram_clear_done));
   dt_system #(.DEPTH(2)) dt_system_i (.sys_clk(sys_clk), .rst_n(rst_n), .bus(bus),
      .grant_master(grant_master), .grant_slave(grant_slave), .burst(burst), .dev_writes(dev_writes),
      .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready), .rd_data(rd_data),
      .rd_valid(rd_valid), .rd_ready(rd_ready), .parity_err(parity_err), .dev_busy(dev_busy),
      .dev_irq(dev_irq));
   dt_bus_sva dt_bus_sva_i (.sys_clk(sys_clk), .rst_n(rst_n), .d_line(bus.d_line), .dp_line(bus.dp_line),
      .d_dev_oe(bus.d_dev_oe), .d_bus_oe(bus.d_bus_oe), .ta_n_line(bus.ta_n_line),
      .ta_n_dev_o(bus.ta_n_dev_o), .ta_n_dev_oe(bus.ta_n_dev_oe), .dbb_n_o(bus.dbb_n_o),
      .dbb_n_oe(bus.dbb_n_oe), .slave_claim_out(bus.slave_claim_out),
      .master_data_grant_in(bus.master_data_grant_in), .slave_data_grant_in(bus.slave_data_grant_in));
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   task end_of_test();
      if (n_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   function automatic logic [63:0] beat(input int k);
      return 64'hf0e1d2c3b4a59687 + 64'(k);
   endfunction
   // every acknowledged beat seen on the wire, whoever drives it
   always @(posedge sys_clk) begin
      if (rst_n === 1'b1) begin
         `CHECK(parity_err, 1'b0, "parity flag")
         if (bus.gbl_n === 1'b0) gbl_cnt++;
         if (bus.ta_n_line === 1'b0) begin
            for (int i = 0; i < PAR_W; i++) `CHECK(^{bus.d_line[i*8 +: 8], bus.dp_line[i]}, 1'b1, "lane")
         end
      end
   end
   task automatic clear_check();
      repeat (RAM_DEPTH / 2) @(posedge sys_clk);
      `CHECK(ram_clear_done, 1'b0, "clear too short")
      `WAITC(ram_clear_done)
      `CHECK(busy, 1'b0, "busy after clear")
   endtask
   task automatic xfer(input bit slave, input bit snd, input bit brst);
      int n, g0;
      n = brst ? BURST_BEATS : 1;
      g0 = gbl_cnt;
      @(posedge sys_clk);
      mst_req <= !slave; mst_write <= snd; mst_burst <= brst; mst_global <= brst;
      slv_claim <= slave; slv_read <= snd; slv_burst <= brst; burst <= brst; dev_writes <= snd;
      grant_master <= !slave; grant_slave <= slave;
      fork
         begin
            for (int i = 0; i < n; i++) begin
               tx_data <= beat(seq + i); wr_data <= beat(seq + i); tx_valid <= snd; wr_valid <= !snd;
               `WAITC(snd ? tx_ready : wr_ready)
            end
            tx_valid <= 1'b0; wr_valid <= 1'b0;
         end
         begin
            rx_ready <= 1'b0; rd_ready <= 1'b0;
            // stall the receiver so bursts back up into the buffer
            if (brst) repeat (8) @(posedge sys_clk);
            rx_ready <= 1'b1; rd_ready <= 1'b1;
            for (int i = 0; i < n; i++) begin
               `WAITC(snd ? rd_valid : rx_valid)
               `CHECK(snd ? rd_data : rx_data, beat(seq + i), "beat data")
            end
            rx_ready <= 1'b0; rd_ready <= 1'b0;
         end
         begin
            `WAITC(busy)
            mst_req <= 1'b0; slv_claim <= 1'b0;
         end
      join
      `WAITC(busy == 1'b0)
      grant_master <= 1'b0; grant_slave <= 1'b0;
      repeat (3) @(posedge sys_clk);
      seq += n;
      `CHECK(gbl_cnt != g0, !slave && brst, "global mark")
      `CHECK(bus.dbb_n_oe, 1'b0, "busy line held")
      `CHECK(bus.d_line, 64'hffffffffffffffff, "idle data")
   endtask
   initial begin
      rst_n = 1'b0; mst_req = 1'b0; mst_write = 1'b0; mst_burst = 1'b0; mst_global = 1'b0;
      slv_claim = 1'b0; slv_read = 1'b0; slv_burst = 1'b0; unit_irq = '0; tx_data = DATA_RST;
      wr_data = DATA_RST; tx_valid = 1'b0; rx_ready = 1'b0; grant_master = 1'b0; grant_slave = 1'b0;
      burst = 1'b0; dev_writes = 1'b0; wr_valid = 1'b0; rd_ready = 1'b0;
      n_errors = 0; tests_run = 0; seq = 0; gbl_cnt = 0;
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      clear_check();
      for (int i = 0; i < IRQ_SRC; i++) begin
         unit_irq <= IRQ_SRC'(1) << i;
         `WAITC(dev_irq)
         `CHECK(bus.irq_n, 1'b0, "irq asserted")
         unit_irq <= '0;
         `WAITC(dev_irq == 1'b0)
         `CHECK(bus.irq_n, 1'b1, "irq negated")
      end
      for (int t = 0; t < 8; t++) xfer(t[2], t[1], t[0]);
      // reset in mid tenure: device waits for data that never comes
      @(posedge sys_clk);
      mst_req <= 1'b1; mst_write <= 1'b1; mst_burst <= 1'b1; grant_master <= 1'b1; burst <= 1'b1;
      dev_writes <= 1'b1;
      `WAITC(bus.dbb_n_oe && !bus.dbb_n_o)
      rst_n <= 1'b0; mst_req <= 1'b0; grant_master <= 1'b0;
      #1;
      `CHECK(busy, 1'b0, "busy in reset")
      `CHECK(bus.dbb_n_oe, 1'b0, "busy line in reset")
      `CHECK(bus.d_dev_oe, 1'b0, "data in reset")
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'b1;
      clear_check();
      xfer(1'b0, 1'b1, 1'b1);
      end_of_test();
   end
endmodule // host_bus_data_tenure_test
